/* File: design/sbh_host_port.v */
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "sbh_consts.vh"
module sbh_host_port (
  input  wire                   aclk,
  input  wire                   aresetn,
  // Shared bus pins
  input  wire [15:0]            sd_in,
  output wire [15:0]            sd_out,
  output wire [15:0]            sd_oe,
  input  wire                   cmd_in,
  input  wire                   wr_strobe_n,
  input  wire                   rd_strobe_n,
  // Strap pins
  input  wire                   bus_width_strap_pin_in,
  output wire                   bus_width_strap_pin_out,
  output wire                   bus_width_strap_pin_oe,
  input  wire                   eeprom_present_strap_pin_in,
  output wire                   eeprom_present_strap_pin_out,
  output wire                   eeprom_present_strap_pin_oe,
  input  wire                   endian_strap_pin_in,
  output wire                   endian_strap_pin_out,
  output wire                   endian_strap_pin_oe,
  // AXI4-Lite slave
  input  wire [`SBH_AXI_AW-1:0] s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  output wire                   s_axi_awready,
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output wire                   s_axi_wready,
  output wire [1:0]             s_axi_bresp,
  output wire                   s_axi_bvalid,
  input  wire                   s_axi_bready,
  input  wire [`SBH_AXI_AW-1:0] s_axi_araddr,
  input  wire                   s_axi_arvalid,
  output wire                   s_axi_arready,
  output wire [31:0]            s_axi_rdata,
  output wire [1:0]             s_axi_rresp,
  output wire                   s_axi_rvalid,
  input  wire                   s_axi_rready
);
  function [15:0] sbh_swap16;
    input [15:0] v;
    begin
      sbh_swap16 = {v[7:0], v[15:8]};
    end
  endfunction

  function [3:0] sbh_lane;
    input [1:0] a;
    begin
      sbh_lane = 4'h1 << a;
    end
  endfunction

  // Pin synchronisation
  wire [`SBH_PIN_W-1:0] pin_q;
  wire [2:0]            strap_q;

  sbh_sync3 #(.W(`SBH_PIN_W)) u_pin_sync (
    .aclk (aclk),
    .d    ({rd_strobe_n, wr_strobe_n, cmd_in, sd_in}),
    .q    (pin_q)
  );

  sbh_sync3 #(.W(3)) u_strap_sync (
    .aclk (aclk),
    .d    ({endian_strap_pin_in, eeprom_present_strap_pin_in, bus_width_strap_pin_in}),
    .q    (strap_q)
  );

  wire [15:0] sd_q  = pin_q[15:0];
  wire        cmd_q = pin_q[`SBH_PIN_CMD];
  wire        wrn_q = pin_q[`SBH_PIN_WRN];
  wire        rdn_q = pin_q[`SBH_PIN_RDN];

  // Strap capture: follows the pins only while reset is held
  reg bus16_r;
  reg eeprom_r;
  reg big_strap_r;
  reg strap_drive_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      bus16_r     <= strap_q[0];
      eeprom_r    <= strap_q[1];
      big_strap_r <= strap_q[2];
    end
  end

  // Strap pins turn to outputs after release, driving the captured level
  always @(posedge aclk) begin
    if (!aresetn) begin
      strap_drive_r <= 1'b0;
    end else begin
      strap_drive_r <= 1'b1;
    end
  end

  assign bus_width_strap_pin_out      = bus16_r;
  assign bus_width_strap_pin_oe       = strap_drive_r;
  assign eeprom_present_strap_pin_out = eeprom_r;
  assign eeprom_present_strap_pin_oe  = strap_drive_r;
  assign endian_strap_pin_out         = big_strap_r;
  assign endian_strap_pin_oe          = strap_drive_r;

  // Software endian bit and effective byte order
  reg  rxfp_endian_r;
  wire big_end = big_strap_r | rxfp_endian_r;

  // Strobe edge detection on synchronised pins
  reg wrn_d_r;
  reg rdn_d_r;
  wire wr_start = wrn_d_r & ~wrn_q;
  wire rd_start = rdn_d_r & ~rdn_q;

  // Latched address and byte enables
  reg [7:0] addr_r;
  reg [3:0] be_r;
  reg [7:0] addr_nxt;
  reg [3:0] be_nxt;

  always @* begin
    addr_nxt = addr_r;
    be_nxt   = be_r;
    if (wr_start & cmd_q) begin
      if (bus16_r) begin
        // Lines 11..8 and 1..0 not looked at here
        addr_nxt = {sd_q[`SBH_SD_A_HI:`SBH_SD_A_WORD_LO], 2'b00};
        be_nxt   = sd_q[`SBH_SD_BE_MSB:`SBH_SD_BE_LSB];
      end else begin
        addr_nxt = sd_q[`SBH_SD_A_HI:0];
        be_nxt   = sbh_lane(sd_q[`SBH_SD_A_BYTE_HI:0]);
      end
    end
  end

  // Data cycle write path
  wire        hi_half = ~(be_r[0] | be_r[1]);
  wire [15:0] wr_half = big_end ? sbh_swap16(sd_q) : sd_q;
  reg  [31:0] mem_wdata;
  reg  [3:0]  mem_be;

  always @* begin
    if (bus16_r) begin
      mem_wdata = {wr_half, wr_half};
      mem_be    = hi_half ? (be_r & 4'hc) : (be_r & 4'h3);
    end else begin
      mem_wdata = {4{sd_q[7:0]}};
      mem_be    = sbh_lane(addr_r[`SBH_SD_A_BYTE_HI:0]);
    end
  end

  wire        mem_we = wr_start & ~cmd_q;
  wire [31:0] mem_rdata;

  sbh_regmem u_mem (
    .aclk  (aclk),
    .we    (mem_we),
    .be    (mem_be),
    .waddr (addr_r[`SBH_SD_A_HI:`SBH_SD_A_WORD_LO]),
    .wdata (mem_wdata),
    .raddr (addr_r[`SBH_SD_A_HI:`SBH_SD_A_WORD_LO]),
    .rdata (mem_rdata)
  );

  // Data cycle read path: word driven on the pins two cycles after strobe edge
  reg        rd_ph_r;
  reg [15:0] sd_out_r;
  reg [15:0] sd_oe_r;
  reg [15:0] rd_sel;
  wire [1:0] lane = addr_r[`SBH_SD_A_BYTE_HI:0];

  always @* begin
    if (bus16_r) begin
      rd_sel = hi_half ? mem_rdata[31:16] : mem_rdata[15:0];
      if (big_end) begin
        rd_sel = sbh_swap16(rd_sel);
      end
    end else begin
      rd_sel = {8'h00, mem_rdata[lane*8 +: 8]};
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      addr_r   <= 8'h00;
      be_r     <= 4'h0;
      wrn_d_r  <= 1'b1;
      rdn_d_r  <= 1'b1;
      rd_ph_r  <= 1'b0;
      sd_out_r <= 16'h0000;
      sd_oe_r  <= 16'h0000;
    end else begin
      addr_r  <= addr_nxt;
      be_r    <= be_nxt;
      wrn_d_r <= wrn_q;
      rdn_d_r <= rdn_q;
      rd_ph_r <= rd_start & ~cmd_q;
      if (rd_ph_r) begin
        sd_out_r <= rd_sel;
      end
      if (rdn_q | cmd_q) begin
        sd_oe_r <= 16'h0000;
      end else if (rd_ph_r) begin
        // Upper lanes stay undriven in 8-bit; pull-downs hold them low
        sd_oe_r <= bus16_r ? 16'hffff : 16'h00ff;
      end
    end
  end

  assign sd_out = sd_out_r;
  assign sd_oe  = sd_oe_r;

  // AXI4-Lite slave: address and data taken in either order
  reg        aw_held_r;
  reg        w_held_r;
  reg [7:0]  awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0]  wstrb_r;
  reg        bvalid_r;
  reg [1:0]  bresp_r;
  reg        rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0]  rresp_r;

  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready  = ~w_held_r & ~bvalid_r;
  assign s_axi_arready = ~rvalid_r;

  wire       aw_fire = s_axi_awvalid & s_axi_awready;
  wire       w_fire  = s_axi_wvalid & s_axi_wready;
  wire       aw_have = aw_held_r | aw_fire;
  wire       w_have  = w_held_r | w_fire;
  wire       do_wr   = aw_have & w_have;
  wire [7:0] wa      = aw_held_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wd     = w_held_r ? wdata_r : s_axi_wdata;
  wire [3:0] ws      = w_held_r ? wstrb_r : s_axi_wstrb;
  wire       ar_fire = s_axi_arvalid & s_axi_arready;

  wire [31:0] cfg_word = ({31'h0, ~bus16_r} << `SBH_CFG_BUS8_BIT)
                       | ({31'h0, bus16_r} << `SBH_CFG_BUS16_BIT)
                       | ({31'h0, eeprom_r} << `SBH_CFG_EEPROM_BIT)
                       | ({31'h0, big_strap_r} << `SBH_CFG_BIG_END_BIT);
  wire [31:0] rxfp_word = {31'h0, rxfp_endian_r} << `SBH_RXFP_ENDIAN_BIT;
  wire [31:0] stat_word = {20'h0, be_r, addr_r};

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      bvalid_r      <= 1'b0;
      bresp_r       <= `SBH_RESP_OKAY;
      rvalid_r      <= 1'b0;
      rdata_r       <= 32'h0000_0000;
      rresp_r       <= `SBH_RESP_OKAY;
      rxfp_endian_r <= `SBH_RXFP_RESET;
    end else begin
      if (do_wr) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        if (wa == `SBH_ADDR_RX_FP) begin
          bresp_r <= `SBH_RESP_OKAY;
          if (ws[1]) begin
            rxfp_endian_r <= wd[`SBH_RXFP_ENDIAN_BIT];
          end
        end else if (wa == `SBH_ADDR_CHIP_CFG || wa == `SBH_ADDR_PIN_STATUS) begin
          // Read-only registers: write dropped
          bresp_r <= `SBH_RESP_OKAY;
        end else begin
          bresp_r <= `SBH_RESP_SLVERR;
        end
      end else begin
        if (aw_fire) begin
          aw_held_r <= 1'b1;
          awaddr_r  <= s_axi_awaddr;
        end
        if (w_fire) begin
          w_held_r <= 1'b1;
          wdata_r  <= s_axi_wdata;
          wstrb_r  <= s_axi_wstrb;
        end
        if (bvalid_r & s_axi_bready) begin
          bvalid_r <= 1'b0;
        end
      end
      if (ar_fire) begin
        rvalid_r <= 1'b1;
        rresp_r  <= `SBH_RESP_OKAY;
        case (s_axi_araddr)
          `SBH_ADDR_CHIP_CFG: begin
            rdata_r <= cfg_word;
          end
          `SBH_ADDR_RX_FP: begin
            rdata_r <= rxfp_word;
          end
          `SBH_ADDR_PIN_STATUS: begin
            rdata_r <= stat_word;
          end
          default: begin
            rdata_r <= 32'h0000_0000;
            rresp_r <= `SBH_RESP_SLVERR;
          end
        endcase
      end else if (rvalid_r & s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;
endmodule
`default_nettype wire

/* File: shared/sbh_consts.vh */
`ifndef SBH_CONSTS_VH
`define SBH_CONSTS_VH

// AXI4-Lite register byte addresses
`define SBH_ADDR_CHIP_CFG     8'h00
`define SBH_ADDR_RX_FP        8'h04
`define SBH_ADDR_PIN_STATUS   8'h08
`define SBH_AXI_AW            8

// AXI responses
`define SBH_RESP_OKAY         2'b00
`define SBH_RESP_SLVERR       2'b10

// Chip config field positions
`define SBH_CFG_BUS8_BIT      6
`define SBH_CFG_BUS16_BIT     7
`define SBH_CFG_EEPROM_BIT    9
`define SBH_CFG_BIG_END_BIT   10

// Rx frame pointer field
`define SBH_RXFP_ENDIAN_BIT   11
`define SBH_RXFP_RESET        1'b0

// Pin status register fields
`define SBH_STAT_BE_LSB       8
`define SBH_STAT_BE_MSB       11

// Shared bus fields in address cycle
`define SBH_SD_BE_MSB         15
`define SBH_SD_BE_LSB         12
`define SBH_SD_A_HI           7
`define SBH_SD_A_WORD_LO      2
`define SBH_SD_A_BYTE_HI      1

// Strap defaults; unused, capture follows the pins while reset is held
`define SBH_STRAP_BUS16_DEF   1'b1
`define SBH_STRAP_EEPROM_DEF  1'b0
`define SBH_STRAP_ENDIAN_DEF  1'b0

// Register memory geometry
`define SBH_MEM_AW            6
`define SBH_MEM_DEPTH         64

// Host pin synchroniser width: sd[15:0], cmd, wr_n, rd_n
`define SBH_PIN_W             19
`define SBH_PIN_CMD           16
`define SBH_PIN_WRN           17
`define SBH_PIN_RDN           18

`endif

/* File: design/sbh_sync3.v */
`timescale 1ns/100ps
`default_nettype none
// Three stage input synchroniser; output follows once stages two and three agree
module sbh_sync3 #(
  parameter W = 1
) (
  input  wire         aclk,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  reg [W-1:0] q_r;
  wire [W-1:0] q_nxt;

  // No reset: straps must flow through while reset is held
  assign q_nxt = (s2_r & s3_r) | (q_r & (s2_r | s3_r));

  always @(posedge aclk) begin
    s1_r <= d;
    s2_r <= s1_r;
    s3_r <= s2_r;
    q_r  <= q_nxt;
  end

  assign q = q_r;
endmodule
`default_nettype wire

/* File: design/sbh_regmem.v */
`timescale 1ns/100ps
`default_nettype none
`include "sbh_consts.vh"
// Byte-writable register space behind the shared bus, registered read
module sbh_regmem (
  input  wire                    aclk,
  input  wire                    we,
  input  wire [3:0]              be,
  input  wire [`SBH_MEM_AW-1:0]  waddr,
  input  wire [31:0]             wdata,
  input  wire [`SBH_MEM_AW-1:0]  raddr,
  output wire [31:0]             rdata
);
  reg [31:0] mem_r [0:`SBH_MEM_DEPTH-1];
  reg [31:0] rdata_r;
  integer i;

  always @(posedge aclk) begin
    if (we) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          mem_r[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
        end
      end
    end
    rdata_r <= mem_r[raddr];
  end

  assign rdata = rdata_r;
endmodule
`default_nettype wire

/* File: verification/sbh_host_port_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module sbh_host_port_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [15:0] sd_oe,
  input wire logic        cmd_in,
  input wire logic        rd_strobe_n,
  input wire logic        bus_width_strap_pin_out,
  input wire logic        bus_width_strap_pin_oe,
  input wire logic        eeprom_present_strap_pin_out,
  input wire logic        eeprom_present_strap_pin_oe,
  input wire logic        endian_strap_pin_out,
  input wire logic        endian_strap_pin_oe,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_strap_hold: assert property ($past(aresetn) |->
    $stable({bus_width_strap_pin_out, eeprom_present_strap_pin_out, endian_strap_pin_out}))
    else $error("strap value moved after reset");
  a_strap_drive: assert property ($past(aresetn) |->
    bus_width_strap_pin_oe && eeprom_present_strap_pin_oe && endian_strap_pin_oe)
    else $error("strap pin not driven after reset");
  a_lane_oe: assert property (sd_oe != 16'h0000 |->
    sd_oe == (bus_width_strap_pin_out ? 16'hffff : 16'h00ff))
    else $error("wrong lanes driven");
  a_cmd_idle: assert property (cmd_in [*8] |-> sd_oe == 16'h0000)
    else $error("bus driven in address phase");
  a_strobe_idle: assert property (rd_strobe_n [*8] |-> sd_oe == 16'h0000)
    else $error("bus driven without read");
  a_cfg_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00 |=>
    {s_axi_rdata[10:9], s_axi_rdata[7:6]} ==
    {endian_strap_pin_out, eeprom_present_strap_pin_out, bus_width_strap_pin_out, !bus_width_strap_pin_out})
    else $error("config bits differ from straps");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
    s_axi_bvalid && s_axi_bresp == (($past(s_axi_awaddr) inside {8'h00, 8'h04, 8'h08}) ? 2'b00 : 2'b10))
    else $error("bad write response");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && s_axi_rresp == (($past(s_axi_araddr) inside {8'h00, 8'h04, 8'h08}) ? 2'b00 : 2'b10))
    else $error("bad read response");
  a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  c_unmapped: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  c_byte_read: cover property (sd_oe == 16'h00ff);
  c_word_read: cover property (sd_oe == 16'hffff);
endmodule
bind sbh_host_port sbh_host_port_properties i_sbh_host_port_properties (.aclk, .aresetn, .sd_oe, .cmd_in,
  .rd_strobe_n, .bus_width_strap_pin_out, .bus_width_strap_pin_oe, .eeprom_present_strap_pin_out,
  .eeprom_present_strap_pin_oe, .endian_strap_pin_out, .endian_strap_pin_oe, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

/* File: verification/sbh_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sbh_host_model (
  input  wire logic        aclk,
  input  wire logic [15:0] sd_out,
  input  wire logic [15:0] sd_oe,
  output wire logic [15:0] sd_in,
  output logic             cmd_in,
  output logic             wr_strobe_n,
  output logic             rd_strobe_n
);
  logic [15:0] hd;
  logic        hoe;
  initial begin
    cmd_in = 1'b0;
    wr_strobe_n = 1'b1;
    rd_strobe_n = 1'b1;
    hd = 16'h0000;
    hoe = 1'b0;
  end
  // Undriven lines fall to the pull-down level
  assign sd_in = (sd_oe & sd_out) | (~sd_oe & {16{hoe}} & hd);
  task automatic cyc(input logic c, input logic [15:0] v, input logic rd, output logic [15:0] q);
    @(posedge aclk);
    cmd_in <= c;
    hd <= v;
    hoe <= !rd;
    if (rd) rd_strobe_n <= 1'b0;
    else wr_strobe_n <= 1'b0;
    // Long strobe covers the pin synchroniser delay
    repeat (10) @(posedge aclk);
    q = sd_in;
    wr_strobe_n <= 1'b1;
    rd_strobe_n <= 1'b1;
    repeat (6) @(posedge aclk);
    hoe <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verification/sbh_host_port_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module sbh_host_port_bench;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [2:0]  st = 3'b110;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [15:0] sd_out, sd_oe, q;
  wire  [15:0] sd_in;
  wire         cmd_in, wr_strobe_n, rd_strobe_n;
  logic        bus_width_strap_pin_out, bus_width_strap_pin_oe, eeprom_present_strap_pin_out;
  logic        eeprom_present_strap_pin_oe, endian_strap_pin_out, endian_strap_pin_oe;
  wire bus_width_strap_pin_in = bus_width_strap_pin_oe ? bus_width_strap_pin_out : st[2];
  wire eeprom_present_strap_pin_in = eeprom_present_strap_pin_oe ? eeprom_present_strap_pin_out : st[1];
  wire endian_strap_pin_in = endian_strap_pin_oe ? endian_strap_pin_out : st[0];
  int err_count = 0, cmp_count = 0;
  sbh_host_port i_sbh_host_port (.aclk, .aresetn, .sd_in, .sd_out, .sd_oe, .cmd_in, .wr_strobe_n,
    .rd_strobe_n, .bus_width_strap_pin_in, .bus_width_strap_pin_out, .bus_width_strap_pin_oe,
    .eeprom_present_strap_pin_in, .eeprom_present_strap_pin_out, .eeprom_present_strap_pin_oe,
    .endian_strap_pin_in, .endian_strap_pin_out, .endian_strap_pin_oe, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  sbh_host_model i_sbh_host_model (.aclk, .sd_out, .sd_oe, .sd_in, .cmd_in, .wr_strobe_n, .rd_strobe_n);
  initial forever #12.5 aclk = ~aclk;
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rst(input logic [2:0] s);
    @(posedge aclk);
    aresetn <= 1'b0;
    st <= s;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, (a inside {8'h00, 8'h04, 8'h08}) ? 32'h0 : 32'h2);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, e);
    chk("rresp", {30'h0, s_axi_rresp}, (a inside {8'h00, 8'h04, 8'h08}) ? 32'h0 : 32'h2);
  endtask
  task automatic pw(input logic c, input logic [15:0] v);
    i_sbh_host_model.cyc(c, v, 1'b0, q);
  endtask
  task automatic pr(input logic [15:0] e);
    i_sbh_host_model.cyc(1'b0, 16'h0000, 1'b1, q);
    chk("sd", {16'h0, q}, {16'h0, e});
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    test_done;
  end
  initial begin
    rst(3'b110);
    axi_rd(8'h00, 32'h0000_0280);
    chk("strap_oe", {29'h0, bus_width_strap_pin_oe, eeprom_present_strap_pin_oe, endian_strap_pin_oe}, 32'h7);
    st <= 3'b001;
    axi_wr(8'h00, 32'hffff_ffff, 4'hf);
    axi_rd(8'h00, 32'h0000_0280);
    axi_wr(8'h40, 32'h0000_0001, 4'hf);
    axi_rd(8'h40, 32'h0000_0000);
    pw(1'b1, 16'h3a57);
    axi_rd(8'h08, 32'h0000_0354);
    pw(1'b0, 16'hbeef);
    pr(16'hbeef);
    pw(1'b1, 16'hc054);
    pw(1'b0, 16'h1234);
    pr(16'h1234);
    pw(1'b1, 16'h3054);
    pr(16'hbeef);
    axi_wr(8'h04, 32'h0000_0800, 4'h1);
    axi_rd(8'h04, 32'h0000_0000);
    axi_wr(8'h04, 32'h0000_0800, 4'h2);
    axi_rd(8'h04, 32'h0000_0800);
    pw(1'b0, 16'h1234);
    axi_wr(8'h04, 32'h0000_0000, 4'h2);
    pr(16'h3412);
    // Word stored swapped above; endian strap alone must swap it back
    rst(3'b101);
    axi_rd(8'h00, 32'h0000_0480);
    pw(1'b1, 16'h3054);
    pr(16'h1234);
    rst(3'b001);
    axi_rd(8'h00, 32'h0000_0440);
    // Upper lines stay low in byte mode
    pw(1'b1, 16'h0015);
    axi_rd(8'h08, 32'h0000_0215);
    pw(1'b0, 16'h005a);
    pw(1'b1, 16'h0016);
    pw(1'b0, 16'h00a5);
    pr(16'h00a5);
    pw(1'b1, 16'h0015);
    pr(16'h005a);
    test_done;
  end
endmodule
`default_nettype wire
